// ==== mcb_pkg.sv ====
// mcb_pkg: constants and types for the machine-check bank status logger
// assumes a single 20 MHz clock domain and a single AHB-Lite slave port
package mcb_pkg;
    // register byte offsets
    localparam logic [7:0] MCB_OFS_STAT_LO = 8'h00;
    localparam logic [7:0] MCB_OFS_STAT_HI = 8'h04;
    localparam logic [7:0] MCB_OFS_LOC_LO = 8'h08;
    localparam logic [7:0] MCB_OFS_LOC_HI = 8'h0C;
    localparam logic [7:0] MCB_OFS_CAP = 8'h10;
    localparam logic [7:0] MCB_OFS_FAULT = 8'h14;
    // global capability bit positions
    localparam int MCB_CAP_CNT_BIT = 10;
    localparam int MCB_CAP_TES_BIT = 11;
    localparam int MCB_CAP_SER_BIT = 24;
    // status field positions
    localparam int MCB_ST_OTHER_LSB = 32;
    localparam int MCB_ST_CNT_LSB = 38;
    localparam int MCB_ST_CNT_MSB = 52;
    localparam int MCB_ST_COL_LSB = 53;
    localparam int MCB_ST_AR_BIT = 55;
    localparam int MCB_ST_SIG_BIT = 56;
    localparam int MCB_ST_PCC_BIT = 57;
    localparam int MCB_ST_LOCV_BIT = 58;
    localparam int MCB_ST_XV_BIT = 59;
    localparam int MCB_ST_EN_BIT = 60;
    localparam int MCB_ST_UC_BIT = 61;
    localparam int MCB_ST_OVER_BIT = 62;
    localparam int MCB_ST_VAL_BIT = 63;
    localparam int MCB_CNT_W = 15;
    // reset values
    localparam logic [63:0] MCB_STAT_RST = 64'h0000_0000_0000_0000;
    localparam logic [63:0] MCB_LOC_RST = 64'h0000_0000_0000_0000;
    localparam logic [14:0] MCB_CNT_RST = 15'h0000;
    // colour codes and the AHB NONSEQ transfer code
    localparam logic [1:0] MCB_COL_NONE = 2'h0;
    localparam logic [1:0] MCB_COL_GREEN = 2'h1;
    localparam logic [1:0] MCB_COL_YELLOW = 2'h2;
    localparam logic [1:0] MCB_HTRANS_NONSEQ = 2'h2;

    // one error report from a source inside the processor
    typedef struct packed {
        logic [31:0] low_code;
        logic [5:0] other_info;
        logic [3:0] impl_56_53;
        logic [14:0] impl_52_38;
        logic enabled;
        logic uncorrected;
        logic monitored;
        logic yellow;
        logic recov_signal;
        logic action_needed;
        logic context_corrupt;
        logic loc_valid;
        logic extra_valid;
        logic [63:0] location;
    } mcb_event_t;

    typedef struct packed {
        logic cnt;
        logic tes;
        logic ser;
    } mcb_cap_t;

    typedef enum logic [1:0] {
        MCB_GP_NONE,
        MCB_GP_STATUS,
        MCB_GP_LOC
    } mcb_gp_t;
endpackage

// ==== mcb_status_logger.sv ====
// mcb_status_logger: one machine-check bank status register, location register,
// overwrite priority and protection-fault reporting, all behind AHB-Lite.
// assumes one clock domain; error events come from same-clock logic.
`timescale 1ns/100ps

module mcb_status_logger
    import mcb_pkg::*;
#(
    parameter bit LOC_IMPL = 1'b1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [31:0] cap_in,
    input wire logic ev_valid,
    input wire mcb_event_t ev_in,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic gp_fault,
    output logic [63:0] status_out
);
    logic [63:0] stat_r;
    logic [63:0] loc_r;
    logic [14:0] cnt_r;
    mcb_cap_t cap;
    logic accept;
    logic take;
    logic [63:0] new_stat;
    logic keep_old;
    logic ph_write_r;
    logic ph_act_r;
    logic [7:0] ph_addr_r;
    logic [31:0] hrdata_r;
    logic gp_r;
    mcb_gp_t gp_kind_r;
    logic sw_clr_stat;
    logic sw_clr_loc;
    logic wr_stat;
    logic wr_loc;
    logic [63:0] stat_view;
    logic clr_hi;
    logic live;

    assign cap = '{cnt: cap_in[MCB_CAP_CNT_BIT], tes: cap_in[MCB_CAP_TES_BIT],
                   ser: cap_in[MCB_CAP_SER_BIT]};

    // an entry whose high word is being cleared this cycle no longer competes, so the event lands
    assign clr_hi = sw_clr_stat && (ph_addr_r == MCB_OFS_STAT_HI);
    assign live = stat_r[MCB_ST_VAL_BIT] && !clr_hi;

    // priority of the incoming event against a live entry
    always_comb begin
        keep_old = 1'b0;
        if (live) begin
            if (stat_r[MCB_ST_UC_BIT] && stat_r[MCB_ST_EN_BIT]) begin
                keep_old = 1'b1;
            end else if (stat_r[MCB_ST_EN_BIT] && !ev_in.enabled) begin
                keep_old = 1'b1;
            end else if (!stat_r[MCB_ST_EN_BIT] && ev_in.enabled) begin
                keep_old = 1'b0;
            end else if (stat_r[MCB_ST_UC_BIT]) begin
                keep_old = 1'b1;
            end else if (ev_in.uncorrected) begin
                keep_old = 1'b0;
            end else begin
                // yellow over green; yellow-yellow keeps the newer one
                keep_old = (stat_r[MCB_ST_COL_LSB +: 2] == MCB_COL_YELLOW) &&
                           !(ev_in.monitored && ev_in.yellow);
            end
        end
    end

    // assemble the status word for the new event from that event alone
    always_comb begin
        new_stat = MCB_STAT_RST;
        new_stat[31:0] = ev_in.low_code;
        new_stat[MCB_ST_OTHER_LSB +: 6] = ev_in.other_info;
        new_stat[MCB_ST_CNT_LSB +: MCB_CNT_W] = ev_in.impl_52_38;
        new_stat[MCB_ST_COL_LSB +: 4] = ev_in.impl_56_53;
        if (cap.tes) begin
            new_stat[MCB_ST_COL_LSB +: 2] = MCB_COL_NONE;
            if (!ev_in.uncorrected && ev_in.monitored) begin
                new_stat[MCB_ST_COL_LSB +: 2] =
                    ev_in.yellow ? MCB_COL_YELLOW : MCB_COL_GREEN;
            end
            new_stat[MCB_ST_AR_BIT] = cap.ser & ev_in.action_needed;
            new_stat[MCB_ST_SIG_BIT] = cap.ser & ev_in.recov_signal;
        end
        new_stat[MCB_ST_PCC_BIT] = ev_in.context_corrupt;
        new_stat[MCB_ST_LOCV_BIT] = ev_in.loc_valid & LOC_IMPL;
        new_stat[MCB_ST_XV_BIT] = ev_in.extra_valid;
        new_stat[MCB_ST_EN_BIT] = ev_in.enabled;
        new_stat[MCB_ST_UC_BIT] = ev_in.uncorrected;
        new_stat[MCB_ST_VAL_BIT] = 1'b1;
    end

    assign accept = ce && ev_valid;
    assign take = accept && !keep_old;

    // bus address phase capture
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ph_act_r <= 1'b0;
            ph_write_r <= 1'b0;
            ph_addr_r <= 8'h00;
        end else if (ce && hready) begin
            ph_act_r <= hsel && (htrans == MCB_HTRANS_NONSEQ);
            ph_write_r <= hwrite;
            ph_addr_r <= haddr[7:0];
        end
    end

    assign wr_stat = ce && ph_act_r && ph_write_r &&
                     (ph_addr_r == MCB_OFS_STAT_LO || ph_addr_r == MCB_OFS_STAT_HI);
    assign wr_loc = ce && ph_act_r && ph_write_r &&
                    (ph_addr_r == MCB_OFS_LOC_LO || ph_addr_r == MCB_OFS_LOC_HI);
    // each 32-bit half is cleared independently; ones refused
    assign sw_clr_stat = wr_stat && (hwdata == 32'h0000_0000);
    assign sw_clr_loc = wr_loc && LOC_IMPL && (hwdata == 32'h0000_0000);

    // status register; an event that is taken wins over a same-cycle clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stat_r <= MCB_STAT_RST;
        end else if (ce) begin
            if (sw_clr_stat) begin
                if (ph_addr_r == MCB_OFS_STAT_LO) begin
                    stat_r[31:0] <= 32'h0000_0000;
                end else begin
                    stat_r[63:32] <= 32'h0000_0000;
                end
            end
            if (take) begin
                stat_r <= new_stat;
            end
            if (accept && live) begin
                stat_r[MCB_ST_OVER_BIT] <= 1'b1;
            end
        end
    end

    // corrected-error counter, only software clears it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_r <= MCB_CNT_RST;
        end else if (ce) begin
            if (sw_clr_stat && ph_addr_r == MCB_OFS_STAT_HI) begin
                cnt_r <= MCB_CNT_RST;
            end
            if (accept && !ev_in.uncorrected && cap.cnt) begin
                // low bits wrap, msb sticks once reached
                cnt_r <= {cnt_r[14] | (&cnt_r[13:0]), cnt_r[13:0] + 14'h0001};
            end
        end
    end

    // location register, replaced only by a winning event
    always_ff @(posedge clk) begin
        if (!rstn) begin
            loc_r <= MCB_LOC_RST;
        end else if (ce) begin
            if (sw_clr_loc) begin
                if (ph_addr_r == MCB_OFS_LOC_LO) begin
                    loc_r[31:0] <= 32'h0000_0000;
                end else begin
                    loc_r[63:32] <= 32'h0000_0000;
                end
            end
            if (take && ev_in.loc_valid && LOC_IMPL) begin
                loc_r <= ev_in.location;
            end
        end
    end

    always_comb begin
        stat_view = stat_r;
        if (cap.cnt) begin
            stat_view[MCB_ST_CNT_MSB:MCB_ST_CNT_LSB] = cnt_r;
        end
    end

    // read data latched with the address phase so it stands in the data phase;
    // a write in the immediately preceding transfer is not yet visible
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (ce && hready && hsel && htrans == MCB_HTRANS_NONSEQ && !hwrite) begin
            case (haddr[7:0])
                MCB_OFS_STAT_LO: hrdata_r <= stat_view[31:0];
                MCB_OFS_STAT_HI: hrdata_r <= stat_view[63:32];
                MCB_OFS_LOC_LO: hrdata_r <= LOC_IMPL ? loc_r[31:0] : 32'h0000_0000;
                MCB_OFS_LOC_HI: hrdata_r <= LOC_IMPL ? loc_r[63:32] : 32'h0000_0000;
                MCB_OFS_CAP: hrdata_r <= cap_in;
                MCB_OFS_FAULT: hrdata_r <= {30'h0000_0000, gp_kind_r};
                default: hrdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // protection faults
    always_ff @(posedge clk) begin
        if (!rstn) begin
            gp_r <= 1'b0;
            gp_kind_r <= MCB_GP_NONE;
        end else if (ce) begin
            gp_r <= 1'b0;
            if (ph_act_r && !ph_write_r) begin
                if (!LOC_IMPL && (ph_addr_r == MCB_OFS_LOC_LO ||
                                  ph_addr_r == MCB_OFS_LOC_HI)) begin
                    gp_r <= 1'b1;
                    gp_kind_r <= MCB_GP_LOC;
                end
            end
            if (wr_stat && hwdata != 32'h0000_0000) begin
                gp_r <= 1'b1;
                gp_kind_r <= MCB_GP_STATUS;
            end
            if (wr_loc && (!LOC_IMPL || hwdata != 32'h0000_0000)) begin
                gp_r <= 1'b1;
                gp_kind_r <= MCB_GP_LOC;
            end
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign gp_fault = gp_r;
    assign status_out = stat_view;

    // checks
    over_on_collide_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && ev_valid && live |=> stat_r[MCB_ST_OVER_BIT])
        else $error("overflow flag not set on collision");
    val_on_event_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && ev_valid |=> stat_r[MCB_ST_VAL_BIT])
        else $error("valid flag not set after event");
    uc_kept_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && ev_valid && live && !sw_clr_stat && stat_r[MCB_ST_UC_BIT] &&
        stat_r[MCB_ST_EN_BIT] |=> stat_r[31:0] == $past(stat_r[31:0]))
        else $error("valid uncorrected entry overwritten");
    uc_wins_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && ev_valid && ev_in.uncorrected && ev_in.enabled |=> stat_r[MCB_ST_UC_BIT])
        else $error("uncorrected event lost");
    cnt_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
        cnt_r[14] && !(ce && sw_clr_stat) |=> cnt_r[14])
        else $error("count overflow bit dropped");
    cnt_inc_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && ev_valid && !ev_in.uncorrected && cap.cnt && !cnt_r[14] && !(&cnt_r[13:0])
        |=> cnt_r == $past(cnt_r) + 15'h0001)
        else $error("corrected count did not increment");
    reserved_ser_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && take && cap.tes && !cap.ser |=> stat_r[56:55] == 2'h0)
        else $error("reserved recovery bits set");
    unmon_col_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && take && cap.tes && !ev_in.monitored |=> stat_r[54:53] == MCB_COL_NONE)
        else $error("unmonitored event posted a colour");
    ones_fault_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_stat && hwdata != 32'h0000_0000 |=> gp_fault)
        else $error("write of ones did not fault");

    // corrected, enabled event meeting a live corrected, enabled entry
    sequence corr_meet_s;
        ce && ev_valid && live && !sw_clr_stat && stat_r[MCB_ST_EN_BIT] &&
            !stat_r[MCB_ST_UC_BIT] && ev_in.enabled && !ev_in.uncorrected;
    endsequence

    // an event that is written into the entry
    sequence win_s;
        ce && take;
    endsequence

    yellow_held_a: assert property (@(posedge clk) disable iff (!rstn)
        corr_meet_s ##0 (stat_r[54:53] == MCB_COL_YELLOW && !(ev_in.monitored && ev_in.yellow))
        |=> stat_r[31:0] == $past(stat_r[31:0]))
        else $error("yellow entry replaced by green");
    yellow_over_a: assert property (@(posedge clk) disable iff (!rstn)
        corr_meet_s ##0 (stat_r[54:53] != MCB_COL_YELLOW && ev_in.monitored && ev_in.yellow)
        |=> stat_r[31:0] == $past(ev_in.low_code))
        else $error("yellow event did not replace green");
    green_new_a: assert property (@(posedge clk) disable iff (!rstn)
        corr_meet_s ##0 (stat_r[54:53] == MCB_COL_GREEN && ev_in.monitored && !ev_in.yellow)
        |=> stat_r[31:0] == $past(ev_in.low_code))
        else $error("green after green kept the first");
    en_beats_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && ev_valid && live && !sw_clr_stat && !stat_r[MCB_ST_EN_BIT] && ev_in.enabled
        |=> stat_r[31:0] == $past(ev_in.low_code))
        else $error("enabled event did not replace disabled entry");
    other_info_a: assert property (@(posedge clk) disable iff (!rstn)
        win_s |=> stat_r[37:32] == $past(ev_in.other_info))
        else $error("other info not taken from event");
    impl_bits_a: assert property (@(posedge clk) disable iff (!rstn)
        win_s ##0 !cap.tes |=> stat_r[56:53] == $past(ev_in.impl_56_53))
        else $error("implementation bits not taken from event");
    recov_bits_a: assert property (@(posedge clk) disable iff (!rstn)
        win_s ##0 (cap.tes && cap.ser)
        |=> stat_r[56:55] == {$past(ev_in.recov_signal), $past(ev_in.action_needed)})
        else $error("recovery flags not taken from event");
    green_post_a: assert property (@(posedge clk) disable iff (!rstn)
        win_s ##0 (cap.tes && !ev_in.uncorrected && ev_in.monitored && !ev_in.yellow)
        |=> stat_r[54:53] == MCB_COL_GREEN)
        else $error("green status not posted");
    flags_from_a: assert property (@(posedge clk) disable iff (!rstn)
        win_s |=> stat_r[59:57] == {$past(ev_in.extra_valid),
            $past(ev_in.loc_valid) & LOC_IMPL, $past(ev_in.context_corrupt)})
        else $error("validity flags not taken from event");
    en_uc_from_a: assert property (@(posedge clk) disable iff (!rstn)
        win_s |=> stat_r[61:60] == {$past(ev_in.uncorrected), $past(ev_in.enabled)})
        else $error("enable or uncorrected flag not taken from event");
    code_from_a: assert property (@(posedge clk) disable iff (!rstn)
        win_s |=> stat_r[31:0] == $past(ev_in.low_code))
        else $error("error code mixed from two events");
    loc_load_a: assert property (@(posedge clk) disable iff (!rstn)
        win_s ##0 (ev_in.loc_valid && LOC_IMPL) |=> loc_r == $past(ev_in.location))
        else $error("location not loaded with winning event");
    over_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
        stat_r[MCB_ST_OVER_BIT] && !(ce && clr_hi) |=> stat_r[MCB_ST_OVER_BIT])
        else $error("overflow flag dropped without software clear");
    cnt_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && clr_hi && !(ev_valid && !ev_in.uncorrected && cap.cnt) |=> cnt_r == MCB_CNT_RST)
        else $error("count not cleared by software");
    cnt_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && !clr_hi && !(ev_valid && !ev_in.uncorrected && cap.cnt) |=> cnt_r == $past(cnt_r))
        else $error("count changed without event or clear");
    stat_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && clr_hi && !ev_valid |=> stat_r[63:32] == 32'h0000_0000)
        else $error("status high word not cleared");
    loc_fault_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_loc && hwdata != 32'h0000_0000 |=> gp_fault)
        else $error("location write of ones did not fault");
    cap_read_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && hready && hsel && htrans == MCB_HTRANS_NONSEQ && !hwrite &&
        haddr[7:0] == MCB_OFS_CAP |=> hrdata == $past(cap_in))
        else $error("capability read data not in data phase");
    bus_okay_a: assert property (@(posedge clk) disable iff (!rstn)
        hreadyout && !hresp)
        else $error("bus response not ready and okay");
endmodule

// ==== tb.sv ====
// tb: self-checking bench for mcb_status_logger
// assumes zero-wait AHB-Lite slave, read data in the data phase, one-cycle fault pulse
`timescale 1ns/100ps
module tb;
    import mcb_pkg::*;
    logic clk, rstn, ce, ev_valid, hsel, hwrite, hready;
    logic [31:0] cap_in, haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, gp_fault, flt;
    logic [63:0] status_out;
    logic [14:0] cnt;
    mcb_event_t ev_in, ea, eb;
    int errors, checks_done;
    // {first, second, second wins}; keys are {variant, en, uc, mon, yellow}
    logic [10:0] pairs [9] = '{{5'h0a, 5'h1a, 1'b1}, {5'h0a, 5'h1b, 1'b1},
        {5'h0b, 5'h1a, 1'b0}, {5'h0b, 5'h1b, 1'b1}, {5'h0a, 5'h1e, 1'b1},
        {5'h0e, 5'h1b, 1'b0}, {5'h0e, 5'h1c, 1'b0}, {5'h02, 5'h1a, 1'b1},
        {5'h09, 5'h19, 1'b1}};
    logic [31:0] caps [3] = '{32'h0000_0800, 32'h0000_0400, 32'h0000_0000};

    assign hready = hreadyout;

    mcb_status_logger #(.LOC_IMPL(1'b1)) u_mcb_status_logger (.clk(clk), .rstn(rstn),
        .ce(ce), .cap_in(cap_in), .ev_valid(ev_valid), .ev_in(ev_in), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .gp_fault(gp_fault), .status_out(status_out));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g,
        input logic [63:0] m);
        checks_done++;
        if ((g & m) !== (e & m)) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e & m, g & m);
        end
    endtask

    // bounded wait; the slave never stalls but the bench assumes nothing
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                errors++;
                complete_run();
            end
            @(posedge clk);
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= MCB_HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        #1 flt = gp_fault;
    endtask

    task automatic ev(input mcb_event_t e);
        @(posedge clk);
        ev_valid <= 1'b1;
        ev_in <= e;
        if (!e.uncorrected) begin
            cnt = {cnt[14] | (&cnt[13:0]), cnt[13:0] + 14'h0001};
        end
        @(posedge clk);
        ev_valid <= 1'b0;
        #1;
    endtask

    task automatic clr();
        bus(MCB_OFS_STAT_LO, 1'b1, 32'h0000_0000);
        bus(MCB_OFS_STAT_HI, 1'b1, 32'h0000_0000);
        cnt = 15'h0000;
    endtask

    function automatic mcb_event_t mk(input logic [4:0] k);
        mcb_event_t e;
        e = '0;
        {e.enabled, e.uncorrected, e.monitored, e.yellow} = k[3:0];
        e.low_code = {3'h5, k, 24'h00_a5c3};
        e.other_info = {1'b1, k};
        e.impl_56_53 = ~k[3:0];
        e.impl_52_38 = {10'h2a5, k};
        {e.recov_signal, e.action_needed, e.context_corrupt} = {k[2], k[0], k[1]};
        {e.loc_valid, e.extra_valid} = {1'b1, k[3]};
        e.location = {32'h0000_0b0b, 27'h000_0000, k};
        return e;
    endfunction

    function automatic logic [63:0] img(input mcb_event_t e, input logic ov);
        logic [63:0] s;
        s = '0;
        s[31:0] = e.low_code;
        s[37:32] = e.other_info;
        s[52:38] = cap_in[10] ? cnt : e.impl_52_38;
        s[56:53] = e.impl_56_53;
        if (cap_in[11]) begin
            s[54:53] = !e.monitored ? MCB_COL_NONE : e.yellow ? MCB_COL_YELLOW : MCB_COL_GREEN;
            s[56:55] = cap_in[24] ? {e.recov_signal, e.action_needed} : 2'h0;
        end
        s[63:57] = {1'b1, ov, e.uncorrected, e.enabled, e.extra_valid, e.loc_valid,
            e.context_corrupt};
        return s;
    endfunction

    // uncorrected entries post MCB_COL_NONE, which img does not model, so colour is left out
    function automatic logic [63:0] msk(input mcb_event_t e);
        return (e.uncorrected && cap_in[11]) ? ~(64'h0000_0000_0000_0003 << 53) : '1;
    endfunction

    initial begin
        {rstn, ev_valid, hsel, hwrite, errors, checks_done} = '0;
        {haddr, hwdata, htrans, ev_in, cnt} = '0;
        ce = 1'b1;
        hsize = 3'h2;
        cap_in = 32'h0100_0c00;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        chk("status_reset", 64'h0, status_out, '1);
        bus(MCB_OFS_CAP, 1'b0, 32'h0000_0000);
        chk("cap_read", {32'h0, cap_in}, {32'h0, rd}, '1);
        chk("okay_resp", 64'h0, 64'(hresp), '1);
        bus(8'h20, 1'b1, 32'hffff_ffff);
        chk("unmapped_fault", 64'h0, 64'(flt), '1);
        $display("test reset done");
        ea = mk(5'h0b);
        ev(ea);
        chk("single", img(ea, 1'b0), status_out, '1);
        bus(MCB_OFS_STAT_HI, 1'b0, 32'h0000_0000);
        chk("read_hi", img(ea, 1'b0) >> 32, {32'h0, rd}, '1);
        bus(MCB_OFS_LOC_LO, 1'b0, 32'h0000_0000);
        chk("loc_read", {32'h0, ea.location[31:0]}, {32'h0, rd}, '1);
        bus(MCB_OFS_STAT_LO, 1'b1, 32'h0000_0001);
        chk("stat_lo_fault", 64'h1, 64'(flt), '1);
        bus(MCB_OFS_STAT_HI, 1'b1, 32'h8000_0000);
        chk("stat_hi_fault", 64'h1, 64'(flt), '1);
        chk("stat_kept", img(ea, 1'b0), status_out, '1);
        bus(MCB_OFS_LOC_HI, 1'b1, 32'h0000_0001);
        chk("loc_fault", 64'h1, 64'(flt), '1);
        bus(MCB_OFS_LOC_LO, 1'b1, 32'h0000_0000);
        chk("loc_clr_ok", 64'h0, 64'(flt), '1);
        bus(MCB_OFS_LOC_LO, 1'b0, 32'h0000_0000);
        chk("loc_cleared", 64'h0, {32'h0, rd}, '1);
        clr();
        chk("clear_ok", 64'h0, 64'(flt), '1);
        chk("cleared", 64'h0, status_out, '1);
        $display("test access done");
        foreach (pairs[i]) begin
            clr();
            ea = mk(pairs[i][10:6]);
            eb = mk(pairs[i][5:1]);
            ev(ea);
            chk("first", img(ea, 1'b0), status_out, msk(ea));
            ev(eb);
            ea = pairs[i][0] ? eb : ea;
            chk("collide", img(ea, 1'b1), status_out, msk(ea));
        end
        $display("test overwrite done");
        foreach (caps[i]) begin
            cap_in <= caps[i];
            clr();
            ea = mk(5'h0f);
            ev(ea);
            chk("cap_mode", img(ea, 1'b0), status_out, msk(ea));
        end
        $display("test capability done");
        cap_in <= 32'h0100_0c00;
        clr();
        ea = mk(5'h0a);
        @(posedge clk);
        ev_in <= ea;
        ev_valid <= 1'b1;
        // 16385 back-to-back corrected events push the count past its msb
        repeat (16385) @(posedge clk);
        ev_valid <= 1'b0;
        cnt = 15'h4001;
        #1;
        chk("count_sticky", img(ea, 1'b1), status_out, '1);
        $display("test counter done");
        complete_run();
    end
endmodule
